// ===== dv/core_model.sv
module core_model (
  input wire clk_i,
  input wire rst_i,
  input wire hold_i,
  input wire ret_req_i,
  output logic core_ready_o,
  output logic reti_o
);
  timeunit 1ns; timeprecision 1ns;
  always @(posedge clk_i) begin
    if (rst_i) begin
      core_ready_o <= 1'b0;
      reti_o <= 1'b0;
    end else begin
      core_ready_o <= !hold_i;
      reti_o <= ret_req_i;
    end
  end
endmodule

// ===== dv/irq_ctrl_sva.sv
module irq_ctrl_sva (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire core_ready_i,
  input wire reti_i,
  input wire push_pc_o,
  input wire [15:0] vector_o,
  input wire [3:0] source_o
);
  timeunit 1ns; timeprecision 1ns;
  logic [1:0] depth;
  logic ga;
  logic [15:0] vt [9];
  wire wtake = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign vt = '{16'h0043, 16'h0003, 16'h0033, 16'h000B, 16'h0013, 16'h001B, 16'h003B,
    16'h0023, 16'h002B};
  // ----------------------------------------
  // shadow of global enable, nesting depth
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      depth <= 2'h0;
      ga <= 1'b0;
    end else begin
      depth <= depth + {1'b0, push_pc_o} - {1'b0, reti_i && depth != 2'h0};
      if (wtake && adr_i == 8'hA8) ga <= dat_i[7];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_bus_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack timing wrong");
  a_global_gate: assert property (push_pc_o |-> $past(ga))
    else $error("accept with global enable off");
  a_vector_map: assert property (push_pc_o |-> vector_o == vt[source_o])
    else $error("vector does not match source");
  a_source_range: assert property (push_pc_o |-> source_o < 4'h9)
    else $error("source index out of range");
  a_push_pulse: assert property (push_pc_o |=> !push_pc_o)
    else $error("accept not a single pulse");
  a_nest_depth: assert property (push_pc_o |-> depth < 2'h2)
    else $error("third nested accept");
  a_ready_gate: assert property (push_pc_o |-> $past(core_ready_i))
    else $error("accept while core not ready");
  a_reserved_zero: assert property (ack_o && $past(!we_i && adr_i == 8'hA9)
    |-> dat_o[7:2] == 6'h00)
    else $error("reserved bits not zero");
  c_nested: cover property (push_pc_o && depth == 2'h1);
  c_write: cover property (ack_o && we_i);
  c_return: cover property (reti_i && depth != 2'h0);
endmodule
bind two_level_interrupt_controller irq_ctrl_sva chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .core_ready_i(core_ready_i), .reti_i(reti_i),
  .push_pc_o(push_pc_o), .vector_o(vector_o), .source_o(source_o));

// ===== dv/tb.sv
module tb;
  timeunit 1ns; timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, hold = 0, ret_req = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [11:0] src = 12'h000;
  logic [7:0] ra [3] = '{8'hA8, 8'hA9, 8'hB8};
  logic [31:0] re [3] = '{32'hFF, 32'h03, 32'hFF};
  logic [15:0] vt [12] = '{16'h0043, 16'h0003, 16'h0033, 16'h000B, 16'h0013, 16'h001B,
    16'h003B, 16'h0023, 16'h002B, 16'h003B, 16'h0023, 16'h002B};
  wire [31:0] dat_o;
  wire [15:0] vector_o;
  wire [3:0] source_o;
  wire ack_o, irq_o, core_irq_o, push_pc_o, ready, reti;
  int fail_count = 0, samples_checked = 0;
  two_level_interrupt_controller DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o), .supply_monitor_irq_i(src[0]), .ext0_irq_flag_i(src[1]),
    .adc_done_flag_i(src[2]), .timer0_overflow_flag_i(src[3]), .ext1_irq_flag_i(src[4]),
    .timer1_overflow_flag_i(src[5]), .twowire_irq_flag_i(src[6]),
    .uart_rx_done_flag_i(src[7]), .timer2_overflow_flag_i(src[8]), .spi_irq_flag_i(src[9]),
    .uart_tx_done_flag_i(src[10]), .timer2_external_flag_i(src[11]), .core_ready_i(ready),
    .reti_i(reti), .core_irq_o(core_irq_o), .vector_o(vector_o), .push_pc_o(push_pc_o),
    .source_o(source_o));
  core_model core (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .ret_req_i(ret_req),
    .core_ready_o(ready), .reti_o(reti));
  initial forever #10 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [31:0] e);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    if (!w) chk(dat_o, e);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic take(input logic [15:0] v);
    do @(posedge clk_i); while (push_pc_o !== 1'b1);
    chk({16'h0, vector_o}, {16'h0, v});
  endtask
  task automatic quiet(input int n);
    repeat (n) @(posedge clk_i) chk({31'h0, push_pc_o}, 32'h0);
  endtask
  task automatic ret;
    @(posedge clk_i);
    ret_req <= 1'b1;
    @(posedge clk_i);
    ret_req <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    close_out;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) bus(0, ra[i], 0, 0);
    bus(0, 8'h10, 0, 0);
    for (int i = 0; i < 3; i++) begin
      bus(1, ra[i], 8'hFF, 0);
      bus(0, ra[i], 0, re[i]);
    end
    $display("test registers done");
    bus(1, 8'hB8, 8'h00, 0);
    bus(1, 8'hA8, 8'h7F, 0);
    src <= 12'h1FF;
    quiet(10);
    bus(1, 8'hA8, 8'hFF, 0);
    for (int i = 0; i < 12; i++) begin
      if (i > 8) src[i] <= 1'b1;
      take(vt[i]);
      src[i] <= 1'b0;
      ret;
    end
    chk({31'h0, irq_o}, 32'h0);
    bus(1, 8'hC8, 8'h01, 0);
    chk({31'h0, irq_o}, 32'h1);
    bus(1, 8'hCC, 8'h07, 0);
    chk({31'h0, irq_o}, 32'h0);
    bus(0, 8'hC4, 0, 0);
    $display("test polling done");
    bus(1, 8'hB8, 8'h08, 0);
    src <= 12'h022;
    take(16'h001B);
    src[5] <= 1'b0;
    ret;
    take(16'h0003);
    src[1] <= 1'b0;
    src[4] <= 1'b1;
    quiet(10);
    src[5] <= 1'b1;
    take(16'h001B);
    src[5] <= 1'b0;
    bus(0, 8'hC0, 0, 32'h00050C10);
    ret;
    quiet(10);
    ret;
    take(16'h0013);
    src[4] <= 1'b0;
    ret;
    hold <= 1'b1;
    repeat (2) @(posedge clk_i);
    src[1] <= 1'b1;
    quiet(10);
    chk({31'h0, core_irq_o}, 32'h1);
    hold <= 1'b0;
    take(16'h0003);
    src[1] <= 1'b0;
    ret;
    $display("test priority done");
    close_out;
  end
endmodule

// ===== include/irq_ctrl_defs.vh
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define IRQ_ENABLE_ADDR 8'hA8
`define IRQ_ENABLE2_ADDR 8'hA9
`define IRQ_PRIORITY_ADDR 8'hB8
`define IRQ_STATUS_ADDR 8'hC0
`define IRQ_EVT_STATUS_ADDR 8'hC4
`define IRQ_EVT_ENABLE_ADDR 8'hC8
`define IRQ_EVT_CLEAR_ADDR 8'hCC
`define IRQ_REG_RESET 8'h00
// ----------------------------------------------------------------
// enable bit positions
// ----------------------------------------------------------------
`define GLOBAL_EN_BIT 7
`define SUPPLY_EN_BIT 1
`define TWOWIRE_EN_BIT 0
// ----------------------------------------------------------------
// source index, polling order (0 first)
// ----------------------------------------------------------------
`define SRC_SUPPLY 0
`define SRC_EXT0 1
`define SRC_ADC 2
`define SRC_TIMER0 3
`define SRC_EXT1 4
`define SRC_TIMER1 5
`define SRC_TWOWIRE 6
`define SRC_UART 7
`define SRC_TIMER2 8
`define NUM_SRC 9
// ----------------------------------------------------------------
// vectors
// ----------------------------------------------------------------
`define VEC_EXT0 16'h0003
`define VEC_TIMER0 16'h000B
`define VEC_EXT1 16'h0013
`define VEC_TIMER1 16'h001B
`define VEC_UART 16'h0023
`define VEC_TIMER2 16'h002B
`define VEC_ADC 16'h0033
`define VEC_TWOWIRE 16'h003B
`define VEC_SUPPLY 16'h0043
// ----------------------------------------------------------------
// event status bits
// ----------------------------------------------------------------
`define EVT_ACCEPT 0
`define EVT_PREEMPT 1
`define EVT_RETURN 2
`define EVT_WIDTH 3
`endif

// ===== src/irq_arbiter.v
`include "irq_ctrl_defs.vh"
module irq_arbiter (
  input wire [8:0] req_i,
  output reg found_o,
  output reg [3:0] index_o
);
  integer k;
  // fixed polling: lowest index wins
  always @* begin
    found_o = 1'b0;
    index_o = 4'h0;
    for (k = `NUM_SRC - 1; k >= 0; k = k - 1) begin
      if (req_i[k]) begin
        found_o = 1'b1;
        index_o = k[3:0];
      end
    end
  end
endmodule

// ===== src/two_level_interrupt_controller.v
// Design decision made here: the Wishbone interface to the registers.
`include "irq_ctrl_defs.vh"
module two_level_interrupt_controller (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire irq_o,
  input wire supply_monitor_irq_i,
  input wire ext0_irq_flag_i,
  input wire adc_done_flag_i,
  input wire timer0_overflow_flag_i,
  input wire ext1_irq_flag_i,
  input wire timer1_overflow_flag_i,
  input wire twowire_irq_flag_i,
  input wire spi_irq_flag_i,
  input wire uart_rx_done_flag_i,
  input wire uart_tx_done_flag_i,
  input wire timer2_overflow_flag_i,
  input wire timer2_external_flag_i,
  input wire core_ready_i,
  input wire reti_i,
  output wire core_irq_o,
  output reg [15:0] vector_o,
  output reg push_pc_o,
  output reg [3:0] source_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam IDLE = 1'b0;
  localparam TAKE = 1'b1;
  reg [7:0] interrupt_enable;
  reg [1:0] secondary_interrupt_enable;
  reg [7:0] interrupt_priority;
  reg [`EVT_WIDTH-1:0] evt_status;
  reg [`EVT_WIDTH-1:0] evt_enable;
  reg high_in_service;
  reg low_in_service;
  reg state;
  reg req_pending;
  wire [8:0] raw;
  wire [8:0] src_en;
  wire [8:0] src_hi;
  wire [8:0] active;
  wire [8:0] hi_req;
  wire [8:0] lo_req;
  wire hi_found;
  wire lo_found;
  wire [3:0] hi_idx;
  wire [3:0] lo_idx;
  wire hi_ok;
  wire lo_ok;
  wire bus_req;
  wire wr;
  wire take;
  wire [3:0] win_idx;
  wire win_hi;
  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [15:0] vec_of;
    input [3:0] idx;
    begin
      case (idx)
        4'h0: vec_of = `VEC_SUPPLY;
        4'h1: vec_of = `VEC_EXT0;
        4'h2: vec_of = `VEC_ADC;
        4'h3: vec_of = `VEC_TIMER0;
        4'h4: vec_of = `VEC_EXT1;
        4'h5: vec_of = `VEC_TIMER1;
        4'h6: vec_of = `VEC_TWOWIRE;
        4'h7: vec_of = `VEC_UART;
        default: vec_of = `VEC_TIMER2;
      endcase
    end
  endfunction
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction
  // ----------------------------------------------------------------
  // source mapping in polling order
  // ----------------------------------------------------------------
  assign raw = {timer2_overflow_flag_i | timer2_external_flag_i,
                uart_rx_done_flag_i | uart_tx_done_flag_i,
                twowire_irq_flag_i | spi_irq_flag_i,
                timer1_overflow_flag_i, ext1_irq_flag_i, timer0_overflow_flag_i,
                adc_done_flag_i, ext0_irq_flag_i, supply_monitor_irq_i};
  assign src_en = {interrupt_enable[5], interrupt_enable[4],
                   secondary_interrupt_enable[`TWOWIRE_EN_BIT], interrupt_enable[3],
                   interrupt_enable[2], interrupt_enable[1], interrupt_enable[6],
                   interrupt_enable[0],
                   secondary_interrupt_enable[`SUPPLY_EN_BIT]};
  // supply monitor has no priority bit and stays low level
  assign src_hi = {interrupt_priority[5], interrupt_priority[4], interrupt_priority[7],
                   interrupt_priority[3], interrupt_priority[2], interrupt_priority[1],
                   interrupt_priority[6], interrupt_priority[0], 1'b0};
  assign active = raw & src_en & {9{interrupt_enable[`GLOBAL_EN_BIT]}};
  assign hi_req = active & src_hi;
  assign lo_req = active & ~src_hi;
  irq_arbiter u_hi (
    .req_i(hi_req),
    .found_o(hi_found),
    .index_o(hi_idx)
  );
  irq_arbiter u_lo (
    .req_i(lo_req),
    .found_o(lo_found),
    .index_o(lo_idx)
  );
  // ----------------------------------------------------------------
  // dispatch
  // ----------------------------------------------------------------
  assign hi_ok = hi_found & ~high_in_service;
  assign lo_ok = lo_found & ~high_in_service & ~low_in_service;
  assign win_hi = hi_ok;
  assign win_idx = hi_ok ? hi_idx : lo_idx;
  assign take = (state == IDLE) & (hi_ok | lo_ok) & core_ready_i;
  assign core_irq_o = req_pending;
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= IDLE;
      req_pending <= 1'b0;
      vector_o <= 16'h0000;
      push_pc_o <= 1'b0;
      source_o <= 4'h0;
      high_in_service <= 1'b0;
      low_in_service <= 1'b0;
    end else begin
      push_pc_o <= 1'b0;
      req_pending <= (hi_ok | lo_ok) & (state == IDLE);
      case (state)
        IDLE: begin
          if (take) begin
            vector_o <= vec_of(win_idx);
            source_o <= win_idx;
            push_pc_o <= 1'b1;
            state <= TAKE;
            if (win_hi)
              high_in_service <= 1'b1;
            else
              low_in_service <= 1'b1;
          end else if (reti_i) begin
            // return ends the innermost level in service
            if (high_in_service)
              high_in_service <= 1'b0;
            else
              low_in_service <= 1'b0;
          end
        end
        TAKE: begin
          state <= IDLE;
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign wr = bus_req & we_i & sel_i[0];
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      interrupt_enable <= `IRQ_REG_RESET;
      secondary_interrupt_enable <= 2'b00;
      interrupt_priority <= `IRQ_REG_RESET;
      evt_enable <= {`EVT_WIDTH{1'b0}};
    end else begin
      ack_o <= bus_req;
      if (wr && hit(adr_i, `IRQ_ENABLE_ADDR))
        interrupt_enable <= dat_i[7:0];
      if (wr && hit(adr_i, `IRQ_ENABLE2_ADDR))
        secondary_interrupt_enable <= dat_i[1:0];
      if (wr && hit(adr_i, `IRQ_PRIORITY_ADDR))
        interrupt_priority <= dat_i[7:0];
      if (wr && hit(adr_i, `IRQ_EVT_ENABLE_ADDR))
        evt_enable <= dat_i[`EVT_WIDTH-1:0];
      if (bus_req && !we_i) begin
        case (adr_i)
          `IRQ_ENABLE_ADDR: dat_o <= {24'h000000, interrupt_enable};
          `IRQ_ENABLE2_ADDR: dat_o <= {30'h00000000, secondary_interrupt_enable};
          `IRQ_PRIORITY_ADDR: dat_o <= {24'h000000, interrupt_priority};
          `IRQ_STATUS_ADDR: dat_o <= {12'h000, source_o, 4'h0,
                                      high_in_service, low_in_service, 1'b0, active};
          `IRQ_EVT_STATUS_ADDR: dat_o <= {29'h00000000, evt_status};
          `IRQ_EVT_ENABLE_ADDR: dat_o <= {29'h00000000, evt_enable};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // event status, set wins over clear
  // ----------------------------------------------------------------
  wire [`EVT_WIDTH-1:0] evt_set;
  wire [`EVT_WIDTH-1:0] evt_clr;
  assign evt_set = {reti_i & (state == IDLE) & ~take & (high_in_service | low_in_service),
                    take & win_hi & low_in_service, take};
  assign evt_clr = (wr && hit(adr_i, `IRQ_EVT_CLEAR_ADDR)) ?
                   dat_i[`EVT_WIDTH-1:0] : {`EVT_WIDTH{1'b0}};
  always @(posedge clk_i) begin
    if (rst_i)
      evt_status <= {`EVT_WIDTH{1'b0}};
    else
      evt_status <= (evt_status & ~evt_clr) | evt_set;
  end
  assign irq_o = |(evt_status & evt_enable);
endmodule
